/* File: hdl/tcdma_cfg.svh */
// constants of the two-channel dma controller: offsets, fields, resets
// assumes bit 0 is the lsb; word-aligned byte offsets on the register port
`ifndef TCDMA_CFG_SVH
`define TCDMA_CFG_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TCDMA_OFF_SRC0 12'h200
`define TCDMA_OFF_TGT0 12'h204
`define TCDMA_OFF_LEN0 12'h208
`define TCDMA_OFF_CHAN0_MODE_CONTROL 12'h20c
`define TCDMA_OFF_SRC1 12'h210
`define TCDMA_OFF_TGT1 12'h214
`define TCDMA_OFF_LEN1 12'h218
`define TCDMA_OFF_CHAN1_MODE_CONTROL 12'h21c
`define TCDMA_OFF_DEV0 12'h220
`define TCDMA_OFF_DEV1 12'h224
`define TCDMA_OFF_REM0 12'h228
`define TCDMA_OFF_REM1 12'h22c
`define TCDMA_CH_STRIDE 12'h010
// ----------------------------------------------------------------------
// mode register fields, common part
// ----------------------------------------------------------------------
`define TCDMA_B_EN 31
`define TCDMA_B_IRQEN 29
`define TCDMA_B_PPEN 28
`define TCDMA_B_TC 27
`define TCDMA_B_M2M 26
`define TCDMA_B_DEM 25
`define TCDMA_F_IOW_HI 24
`define TCDMA_F_IOW_LO 23
`define TCDMA_F_DIR_HI 22
`define TCDMA_F_DIR_LO 21
`define TCDMA_F_REC_HI 20
`define TCDMA_F_REC_LO 16
`define TCDMA_F_WS_HI 15
`define TCDMA_F_WS_LO 11
// channel 0 mode only
`define TCDMA_B_ROT 10
`define TCDMA_F_TOUT_HI 8
`define TCDMA_F_TOUT_LO 0
// channel 1 mode only
`define TCDMA_B_ACK0L 10
`define TCDMA_B_ACK1L 9
`define TCDMA_B_SEL0L 8
`define TCDMA_B_SEL1L 7
`define TCDMA_B_ACK1A 6
`define TCDMA_B_TO0 5
`define TCDMA_B_TO1 4
// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define TCDMA_RST_WORD 32'h0000_0000
`define TCDMA_RST_DEV 32'hffff_f000
`define TCDMA_WMASK_CHAN0_MODE_CONTROL 32'hb7ff_fdff
`define TCDMA_WMASK_CHAN1_MODE_CONTROL 32'hb7ff_ff80
`define TCDMA_WMASK_DEV 32'hffff_f000
`endif

/* File: hdl/tcdma_pkg.sv */
// types of the two-channel dma controller
// assumes tcdma_cfg.svh holds all numbers
package tcdma_pkg;
  // --------------------------------------------------------------------
  // engine states and field encodings
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    TCDMA_IDLE = 3'b000,
    TCDMA_MRD  = 3'b001,
    TCDMA_MWR  = 3'b010,
    TCDMA_IOC  = 3'b011,
    TCDMA_REC  = 3'b100
  } tcdma_state_e;
  typedef enum logic [1:0] {
    TCDMA_DIR_M2M = 2'b00,
    TCDMA_DIR_M2IO = 2'b01,
    TCDMA_DIR_IO2M = 2'b10
  } tcdma_dir_e;
  // memory master request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tcdma_mem_s;
  // external i/o command
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } tcdma_io_s;
endpackage

/* File: hdl/tcdma_top.sv */
// two-channel dma controller: register port, memory master, 8-bit i/o
// assumes inputs synchronous to ref_clk_i; mem_ack_i is a one-cycle pulse
`include "tcdma_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tcdma_top import tcdma_pkg::*; #(
  parameter int LEN_W = 17
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output var  logic [31:0] reg_rdata_o,
  output var  tcdma_mem_s  mem_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  output var  tcdma_io_s   io_o,
  input  wire logic [7:0]  io_rdata_i,
  input  wire logic        io_ready_line_i,
  input  wire logic [1:0]  dreq_i,
  output var  logic [1:0]  dack_o,
  output var  logic [1:0]  sel_o,
  output var  logic        irq_o
);
  // the register map only has room for a 17-bit count
  if (LEN_W != 17) begin : g_bad_len
    $error("length counter must be 17 bits");
  end
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [31:0] src_r [2];
  logic [31:0] tgt_r [2];
  logic [LEN_W-1:0] len_r [2];
  logic [LEN_W-1:0] rem_r [2];
  logic [31:0] mode_r [2];
  logic [31:0] dev_r [2];
  logic [1:0] tc_r;
  logic [1:0] to_r;
  logic [1:0] blk_r;
  tcdma_state_e state_r, state_nxt;
  logic ch_r;
  logic last_r;
  logic [31:0] data_r;
  logic [4:0] cyc_r;
  logic [8:0] tout_r;
  logic [1:0] req_w;
  logic [1:0] unit_done_w;
  logic [1:0] tout_hit_w;
  // ----------------------------------------------------------------------
  // field decode of the active channel; timeout limit and rotation come from channel 0
  // ----------------------------------------------------------------------
  wire [31:0] cm_w = mode_r[ch_r];
  wire m2m_w = cm_w[`TCDMA_B_M2M];
  wire [1:0] dir_w = m2m_w ? TCDMA_DIR_M2M : cm_w[`TCDMA_F_DIR_HI:`TCDMA_F_DIR_LO];
  wire io_rd_dir_w = dir_w[1];
  wire [4:0] rec_w = cm_w[`TCDMA_F_REC_HI:`TCDMA_F_REC_LO];
  wire [4:0] ws_w = cm_w[`TCDMA_F_WS_HI:`TCDMA_F_WS_LO];
  wire [8:0] tlim_w = mode_r[0][`TCDMA_F_TOUT_HI:`TCDMA_F_TOUT_LO];
  wire rot_w = mode_r[0][`TCDMA_B_ROT];
  // address step follows the counting unit; copy always moves words
  wire [1:0] iow_w = cm_w[`TCDMA_F_IOW_HI:`TCDMA_F_IOW_LO];
  wire [31:0] step_w = m2m_w ? 32'h4 :
    (iow_w == 2'b01) ? 32'h2 : (iow_w == 2'b10) ? 32'h4 : 32'h1;
  // command done once wait states spent and device no longer stretches or the ready timeout hits
  wire ws_spent_w = (cyc_r >= ws_w);
  wire tout_w = ws_spent_w && io_ready_line_i && (tout_r >= tlim_w);
  wire ioc_end_w = (state_r == TCDMA_IOC) && ws_spent_w
    && (!io_ready_line_i || tout_w);
  wire rec_end_w = (state_r == TCDMA_REC) && (cyc_r >= rec_w);
  wire mrd_end_w = (state_r == TCDMA_MRD) && mem_ack_i;
  wire mwr_end_w = (state_r == TCDMA_MWR) && mem_ack_i;
  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  wire gnt_w = (req_w == 2'b11) ? (rot_w ? ~last_r : 1'b0)
    : (req_w == 2'b10);
  // ----------------------------------------------------------------------
  // per-channel registers, counters and requests
  // ----------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      localparam logic [11:0] BASE = `TCDMA_OFF_SRC0 + 12'(c) * `TCDMA_CH_STRIDE;
      localparam logic [31:0] WMASK = (c == 0) ? `TCDMA_WMASK_CHAN0_MODE_CONTROL
        : `TCDMA_WMASK_CHAN1_MODE_CONTROL;
      wire wr_src = reg_wr_i && (reg_addr_i == BASE);
      wire wr_tgt = reg_wr_i && (reg_addr_i == BASE + 12'h4);
      wire wr_len = reg_wr_i && (reg_addr_i == BASE + 12'h8);
      wire wr_mod = reg_wr_i && (reg_addr_i == BASE + 12'hc);
      wire wr_dev = reg_wr_i
        && (reg_addr_i == `TCDMA_OFF_DEV0 + 12'(c) * 12'h4);
      wire mine = (ch_r == c);
      wire en = mode_r[c][`TCDMA_B_EN];
      wire demand_select = mode_r[c][`TCDMA_B_DEM];
      wire copy = mode_r[c][`TCDMA_B_M2M];
      // copy ignores demand select and device request
      assign req_w[c] = en && (rem_r[c] != '0)
        && (copy || dreq_i[c] || (!demand_select && blk_r[c]));
      // a unit completes at the last step of its sequence
      assign unit_done_w[c] = mine && (mwr_end_w
        || (rec_end_w && !io_rd_dir_w));
      assign tout_hit_w[c] = mine && ioc_end_w && tout_w;
      wire last_unit = unit_done_w[c] && (rem_r[c] == LEN_W'(1));
      // addresses walk in place, readable by software
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          src_r[c] <= `TCDMA_RST_WORD;
        end else if (wr_src) begin
          src_r[c] <= reg_wdata_i;
        end else if (mine && mrd_end_w) begin
          src_r[c] <= src_r[c] + step_w;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          tgt_r[c] <= `TCDMA_RST_WORD;
        end else if (wr_tgt) begin
          tgt_r[c] <= reg_wdata_i;
        end else if (mine && mwr_end_w) begin
          tgt_r[c] <= tgt_r[c] + step_w;
        end
      end
      // length write reloads the remaining count and rearms the run
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          len_r[c] <= '0;
          rem_r[c] <= '0;
        end else if (wr_len) begin
          len_r[c] <= reg_wdata_i[LEN_W-1:0];
          rem_r[c] <= reg_wdata_i[LEN_W-1:0];
        end else if (unit_done_w[c]) begin
          rem_r[c] <= rem_r[c] - LEN_W'(1);
        end
      end
      // timeout also drops the enable so the channel stops cleanly
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          mode_r[c] <= `TCDMA_RST_WORD;
        end else if (wr_mod) begin
          mode_r[c] <= reg_wdata_i & WMASK;
        end else if (tout_hit_w[c]) begin
          mode_r[c][`TCDMA_B_EN] <= 1'b0;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          dev_r[c] <= `TCDMA_RST_DEV;
        end else if (wr_dev) begin
          dev_r[c] <= reg_wdata_i & `TCDMA_WMASK_DEV;
        end
      end
      // set wins over the clear of a mode write or reprogramming
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          tc_r[c] <= 1'b0;
        end else if (last_unit) begin
          tc_r[c] <= 1'b1;
        end else if (wr_len || (wr_mod && !reg_wdata_i[`TCDMA_B_TC])) begin
          tc_r[c] <= 1'b0;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          to_r[c] <= 1'b0;
        end else if (tout_hit_w[c]) begin
          to_r[c] <= 1'b1;
        end else if (wr_len) begin
          to_r[c] <= 1'b0;
        end
      end
      // block mode keeps going after the first request until done
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          blk_r[c] <= 1'b0;
        end else if (!en || last_unit || wr_len) begin
          blk_r[c] <= 1'b0;
        end else if (dreq_i[c] && !demand_select && !copy) begin
          blk_r[c] <= 1'b1;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TCDMA_IDLE: begin
        if (req_w != 2'b00) begin
          state_nxt = (mode_r[gnt_w][`TCDMA_B_M2M]
            || mode_r[gnt_w][`TCDMA_F_DIR_HI:`TCDMA_F_DIR_LO] == 2'b01)
            ? TCDMA_MRD : TCDMA_IOC;
        end
      end
      TCDMA_MRD: begin
        if (mem_ack_i) begin
          state_nxt = m2m_w ? TCDMA_MWR : TCDMA_IOC;
        end
      end
      TCDMA_MWR: begin
        if (mem_ack_i) begin
          state_nxt = TCDMA_IDLE;
        end
      end
      TCDMA_IOC: begin
        if (ioc_end_w) begin
          state_nxt = TCDMA_REC;
        end
      end
      TCDMA_REC: begin
        if (rec_end_w) begin
          state_nxt = io_rd_dir_w ? TCDMA_MWR : TCDMA_IDLE;
        end
      end
      default: begin
        state_nxt = TCDMA_IDLE;
      end
    endcase
  end
  // state, channel pick and rotation pointer
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_r <= TCDMA_IDLE;
      ch_r <= 1'b0;
      last_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (state_r == TCDMA_IDLE && req_w != 2'b00) begin
        ch_r <= gnt_w;
        last_r <= gnt_w;
      end
    end
  end
  // wait-state / recovery count and ready-timeout count
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || state_nxt != state_r) begin
      cyc_r <= '0;
      tout_r <= '0;
    end else begin
      if (cyc_r != 5'h1f) begin
        cyc_r <= cyc_r + 5'h1;
      end
      if (state_r == TCDMA_IOC && ws_spent_w && io_ready_line_i) begin
        tout_r <= tout_r + 9'h1;
      end
    end
  end
  // data holding between the read and the write half of a unit
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      data_r <= '0;
    end else if (mrd_end_w) begin
      data_r <= mem_rdata_i;
    end else if (ioc_end_w && io_rd_dir_w) begin
      data_r <= {24'h0, io_rdata_i};
    end
  end
  // ----------------------------------------------------------------------
  // registered bus outputs, driven from the next state
  // ----------------------------------------------------------------------
  wire nch_w = (state_r == TCDMA_IDLE) ? gnt_w : ch_r;
  wire nioc_w = (state_nxt == TCDMA_IOC);
  wire nrdd_w = (state_r == TCDMA_IDLE)
    ? mode_r[gnt_w][`TCDMA_F_DIR_HI] : io_rd_dir_w;
  wire [3:0] pol_w = {mode_r[1][`TCDMA_B_SEL1L], mode_r[1][`TCDMA_B_SEL0L],
    mode_r[1][`TCDMA_B_ACK1L], mode_r[1][`TCDMA_B_ACK0L]};
  wire [1:0] act_w = {nioc_w && nch_w, nioc_w && !nch_w};
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      io_o <= '0;
      mem_o <= '0;
      dack_o <= '0;
      sel_o <= '0;
    end else begin
      io_o.rd <= nioc_w && nrdd_w;
      io_o.wr <= nioc_w && !nrdd_w;
      io_o.addr <= dev_r[nch_w];
      io_o.wdata <= (state_r == TCDMA_MRD) ? mem_rdata_i[7:0] : data_r[7:0];
      mem_o.req <= (state_nxt == TCDMA_MRD || state_nxt == TCDMA_MWR)
        && !(mem_ack_i && state_nxt == state_r);
      mem_o.we <= (state_nxt == TCDMA_MWR);
      mem_o.addr <= (state_nxt == TCDMA_MWR) ? tgt_r[nch_w] : src_r[nch_w];
      mem_o.wdata <= (state_r == TCDMA_MRD) ? mem_rdata_i : data_r;
      dack_o <= act_w ^ pol_w[1:0];
      sel_o <= act_w ^ pol_w[3:2];
    end
  end
  // interrupt on any enabled count-done flag
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (tc_r[0] && mode_r[0][`TCDMA_B_IRQEN])
        || (tc_r[1] && mode_r[1][`TCDMA_B_IRQEN]);
    end
  end
  // ----------------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------------
  wire ack1_on_w = (dack_o[1] != pol_w[1]);
  wire [31:0] chan0_mode_control_rd_w = mode_r[0] | ({31'h0, tc_r[0]} << `TCDMA_B_TC);
  wire [31:0] chan1_mode_control_rd_w = mode_r[1] | ({31'h0, tc_r[1]} << `TCDMA_B_TC)
    | ({31'h0, ack1_on_w} << `TCDMA_B_ACK1A)
    | ({31'h0, to_r[0]} << `TCDMA_B_TO0)
    | ({31'h0, to_r[1]} << `TCDMA_B_TO1);
  logic [31:0] rd_mux_w;
  always_comb begin
    case (reg_addr_i)
      `TCDMA_OFF_SRC0: rd_mux_w = src_r[0];
      `TCDMA_OFF_TGT0: rd_mux_w = tgt_r[0];
      `TCDMA_OFF_LEN0: rd_mux_w = {15'h0, len_r[0]};
      `TCDMA_OFF_CHAN0_MODE_CONTROL: rd_mux_w = chan0_mode_control_rd_w;
      `TCDMA_OFF_SRC1: rd_mux_w = src_r[1];
      `TCDMA_OFF_TGT1: rd_mux_w = tgt_r[1];
      `TCDMA_OFF_LEN1: rd_mux_w = {15'h0, len_r[1]};
      `TCDMA_OFF_CHAN1_MODE_CONTROL: rd_mux_w = chan1_mode_control_rd_w;
      `TCDMA_OFF_DEV0: rd_mux_w = dev_r[0];
      `TCDMA_OFF_DEV1: rd_mux_w = dev_r[1];
      `TCDMA_OFF_REM0: rd_mux_w = {15'h0, rem_r[0]};
      `TCDMA_OFF_REM1: rd_mux_w = {15'h0, rem_r[1]};
      default: rd_mux_w = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux_w : 32'h0;
    end
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_last_unit0;
    unit_done_w[0] && rem_r[0] == LEN_W'(1);
  endsequence
  chk_count_done_set: assert property (
    s_last_unit0 |=> tc_r[0] && rem_r[0] == '0)
    else $error("count-done flag not set at zero");
  chk_irq_follows: assert property (
    tc_r[0] && mode_r[0][`TCDMA_B_IRQEN] |=> irq_o)
    else $error("interrupt missing after count done");
  chk_fixed_priority: assert property (
    state_r == TCDMA_IDLE && req_w == 2'b11 && !rot_w |=> ch_r == 1'b0)
    else $error("channel 1 won under fixed priority");
  chk_rotate_turns: assert property (
    state_r == TCDMA_IDLE && req_w == 2'b11 && rot_w |=> ch_r != $past(last_r))
    else $error("rotation did not alternate");
  chk_wait_states: assert property (
    $rose(io_o.rd || io_o.wr) && ws_w == 5'h2 |-> (io_o.rd || io_o.wr) [*3])
    else $error("i/o command shorter than wait states");
  chk_recovery_gap: assert property (
    $fell(io_o.rd || io_o.wr) && rec_w == 5'h3 |-> !(io_o.rd || io_o.wr) [*4])
    else $error("recovery gap too short");
  chk_timeout_flag: assert property (
    tout_hit_w[0] |=> to_r[0] && !mode_r[0][`TCDMA_B_EN])
    else $error("timeout flag not raised");
  chk_no_run_disabled: assert property (
    state_r == TCDMA_IDLE && req_w == 2'b00 |=> state_r == TCDMA_IDLE)
    else $error("transfer started without request");
  chk_ack_polarity: assert property (
    state_r == TCDMA_IDLE && req_w == 2'b00 |=> dack_o[0] == $past(pol_w[0]))
    else $error("idle acknowledge level wrong");
endmodule
`default_nettype wire

/* File: verif/tcdma_io_dev.sv */
// byte-wide external i/o device model facing the dma command port
// assumes commands are levels launched on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module tcdma_io_dev (
  input wire logic ref_clk_i,
  input wire logic cmd_i,
  input wire logic [7:0] stretch_i,
  output logic [7:0] rdata_o,
  output logic ready_o
);
  // ----------------------------------------------------------------
  // command response
  // ----------------------------------------------------------------
  logic [7:0] cnt_r = 8'h00;
  logic [7:0] byte_r = 8'h5a;
  logic cmd_d_r = 1'b0;
  // new byte after each command; only byte-wide transfers offered
  always_ff @(posedge ref_clk_i) begin
    cnt_r <= cmd_i ? cnt_r + 8'h01 : 8'h00;
    cmd_d_r <= cmd_i;
    if (cmd_d_r && !cmd_i) begin
      byte_r <= byte_r + 8'h01;
    end
  end
  // wait line only while selected; released bus shows inverse data
  assign ready_o = cmd_i && (cnt_r < stretch_i);
  assign rdata_o = cmd_i ? byte_r : ~byte_r;
endmodule
`default_nettype wire

/* File: verif/test_two_channel_dma_controller.sv */
// self-checking bench of the dma top with memory and device models
// assumes the design resets synchronously and has no wait on registers
`include "tcdma_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_two_channel_dma_controller import tcdma_pkg::*;;
  // ----------------------------------------------------------------
  // signals and models
  // ----------------------------------------------------------------
  logic ref_clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic mem_ack_i = 0, io_ready_line_i, irq_o;
  logic [11:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, mem_rdata_i = 0, reg_rdata_o, d, s, t;
  logic [7:0] io_rdata_i, stretch = 0;
  logic [1:0] dreq_i = 0, dack_o, sel_o;
  tcdma_mem_s mem_o;
  tcdma_io_s io_o;
  logic [31:0] mem [logic [31:0]];
  int seed = 32'h621af430;
  int n_fail = 0, cmp_count = 0, n_mwr = 0, n_bad = 0, dly = 0;
  int clen = 0, gap = 0, last_len = 0, ncmd = 0, min_gap = 99;
  tcdma_top u_tcdma_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .io_o(io_o), .io_rdata_i(io_rdata_i),
    .io_ready_line_i(io_ready_line_i), .dreq_i(dreq_i), .dack_o(dack_o),
    .sel_o(sel_o), .irq_o(irq_o));
  tcdma_io_dev u_tcdma_io_dev (.ref_clk_i(ref_clk_i),
    .cmd_i(io_o.rd | io_o.wr), .stretch_i(stretch),
    .rdata_o(io_rdata_i), .ready_o(io_ready_line_i));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  // memory slave: random answer delay, one-cycle ack
  always @(posedge ref_clk_i) begin
    mem_ack_i <= 1'b0;
    if (mem_o.req && !mem_ack_i) begin
      if (dly == 0) begin
        mem_ack_i <= 1'b1;
        mem_rdata_i <= mem.exists(mem_o.addr) ? mem[mem_o.addr] : 32'h0;
        if (mem_o.we) begin
          mem[mem_o.addr] = mem_o.wdata;
          n_mwr++;
        end
        dly <= $random(seed) & 3;
      end else begin
        dly <= dly - 1;
      end
    end
  end
  // command length, spacing and strobe levels during commands
  always @(posedge ref_clk_i) begin
    if (io_o.rd | io_o.wr) begin
      clen <= clen + 1;
      if (gap != 0 && ncmd != 0 && gap < min_gap) min_gap <= gap;
      gap <= 0;
      if (dack_o !== 2'b01 || sel_o !== 2'b01 || io_o.wr !== 1'b0
          || io_o.addr !== 32'hfffff000) n_bad <= n_bad + 1;
    end else begin
      if (clen != 0) begin
        last_len <= clen;
        ncmd <= ncmd + 1;
      end
      clen <= 0;
      gap <= gap + 1;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge ref_clk_i);
    chk("irq", 1, irq_o);
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    // reset table, then read-only and unmapped places
    for (int i = 0; i < 12; i++) begin
      rd(12'h200 + 12'(i * 4));
      chk("reset", (i == 8 || i == 9) ? 32'hfffff000 : 32'h0, d);
    end
    wr(`TCDMA_OFF_REM0, $random(seed));
    rd(`TCDMA_OFF_REM0);
    chk("rem_ro", 0, d);
    wr(12'h230, $random(seed));
    rd(12'h230);
    chk("unmapped", 0, d);
    for (int i = 0; i < 8; i++) begin
      s = $random(seed);
      t = (i % 4 == 3) ? `TCDMA_OFF_LEN1 : 12'h200 + 12'(16 * (i % 2) + 4 * (i % 4 / 2));
      wr(t[11:0], s);
      rd(t[11:0]);
      chk("reg_rw", (i % 4 == 3) ? s & 32'h1ffff : s, d);
    end
    // memory copy of three words, then clearing the done flag
    s = $random(seed) & 32'h0000fff0;
    t = s + 32'h1000;
    for (int k = 0; k < 3; k++) mem[s + 4 * k] = $random(seed);
    wr(`TCDMA_OFF_SRC0, s);
    wr(`TCDMA_OFF_TGT0, t);
    wr(`TCDMA_OFF_LEN0, 3);
    wr(`TCDMA_OFF_CHAN0_MODE_CONTROL, 32'ha4000000);
    wait_irq();
    for (int k = 0; k < 3; k++) chk("copy", mem[s + 4 * k], mem[t + 4 * k]);
    rd(`TCDMA_OFF_REM0);
    chk("remaining", 0, d);
    rd(`TCDMA_OFF_CHAN0_MODE_CONTROL);
    chk("done_set", 1, d[27]);
    wr(`TCDMA_OFF_CHAN0_MODE_CONTROL, 0);
    rd(`TCDMA_OFF_CHAN0_MODE_CONTROL);
    chk("done_clr", 0, {d[27], irq_o});
    // i/o to memory, four bytes, two wait states, three recovery
    n_mwr = 0;
    dreq_i <= 2'b01;
    wr(`TCDMA_OFF_TGT0, t);
    wr(`TCDMA_OFF_LEN0, 4);
    wr(`TCDMA_OFF_CHAN0_MODE_CONTROL, 32'ha0431000);
    wait_irq();
    repeat (8) @(posedge ref_clk_i);
    chk("units", 4, n_mwr);
    chk("commands", 4, ncmd);
    chk("cmd_len", 3, last_len);
    chk("gap_ok", 1, min_gap >= 4);
    chk("ack_sel", 0, n_bad);
    wr(`TCDMA_OFF_CHAN0_MODE_CONTROL, 0);
    // device holds the wait line past a limit of six
    stretch <= 200;
    wr(`TCDMA_OFF_LEN0, 1);
    wr(`TCDMA_OFF_CHAN0_MODE_CONTROL, 32'h80400006);
    repeat (100) @(posedge ref_clk_i);
    rd(`TCDMA_OFF_CHAN1_MODE_CONTROL);
    chk("timeout", 1, d[5]);
    rd(`TCDMA_OFF_CHAN0_MODE_CONTROL);
    chk("en_off", 0, d[31]);
    print_verdict();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
